// file: verilog/csm_pkg.sv
// csm_pkg: register map, field positions, modes and reset values for the
// semi-period / frequency measurement counter pair.
// assumes: 32-bit apb slave, word-aligned registers, one clock.
package csm_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_SAVE0 = 8'h08;
    localparam logic [7:0] OFS_SAVE1 = 8'h0c;
    localparam logic [7:0] OFS_PULSE_N = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
    localparam logic [7:0] OFS_CNT0 = 8'h20;
    localparam logic [7:0] OFS_CNT1 = 8'h24;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTL_ARM = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_MODE_W = 3;
    localparam int CTL_SRC_FALL = 4;
    localparam int CTL_GATE_LOW = 5;
    localparam int CTL_SRC_SEL = 6;
    localparam int CTL_GATE_SEL_LO = 8;
    localparam int CTL_GATE_SEL_W = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PULSE_N_RST = 32'h0000_0001;

    // status / interrupt bits
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE0 = 0;
    localparam int IRQ_DONE1 = 1;
    localparam int IRQ_OVR0 = 2;
    localparam int IRQ_OVR1 = 3;

    // counter modes
    typedef enum logic [2:0] {
        CSM_IDLE = 3'h0,
        CSM_SEMI_SINGLE = 3'h1,
        CSM_SEMI_BUF = 3'h2,
        CSM_PERIOD_SINGLE = 3'h3,
        CSM_PERIOD_BUF = 3'h4,
        CSM_PULSE_GEN = 3'h5
    } csm_mode_t;

    // gate routing: pin, function terminal, trigger bus, other counter output
    localparam logic [1:0] GSEL_PIN = 2'h0;
    localparam logic [1:0] GSEL_GFT = 2'h1;
    localparam logic [1:0] GSEL_TRIG = 2'h2;
    localparam logic [1:0] GSEL_PEER = 2'h3;

endpackage : csm_pkg

// file: verilog/csm_counter.sv
// csm_counter: one measurement counter with save register and dma handoff.
// assumes: source and gate arrive already synchronised to pclk.
`timescale 1ns/100ps
module csm_counter #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic arm,
    input wire logic [2:0] mode,
    input wire logic src_fall,
    input wire logic gate_low,
    input wire logic [CNT_W-1:0] pulse_n,
    // measured inputs
    input wire logic src,
    input wire logic gate,
    // results
    output logic [CNT_W-1:0] count,
    output logic [CNT_W-1:0] save,
    output logic gen_out,
    output logic done,
    output logic overrun,
    // dma side
    output logic dma_valid,
    output logic [CNT_W-1:0] dma_data,
    input wire logic dma_ready
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("csm_counter: CNT_W out of range");
    end

    typedef enum {ST_OFF, ST_WAIT, ST_RUN, ST_HOLD} csm_st_t;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic src_prev_q, gate_prev_q, arm_prev_q;
    wire src_edge = src_fall ? (src_prev_q & ~src) : (~src_prev_q & src);
    wire gate_any = gate ^ gate_prev_q;
    wire gate_act = gate ^ gate_low;
    wire gate_lead = gate_any & gate_act;
    wire gate_trail = gate_any & ~gate_act;
    wire arm_rise = arm & ~arm_prev_q;

    csm_st_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, save_q, save_d;
    logic latch, done_p, gen_q, gen_d;

    wire m_semi1 = (mode == csm_pkg::CSM_SEMI_SINGLE);
    wire m_semib = (mode == csm_pkg::CSM_SEMI_BUF);
    wire m_per1 = (mode == csm_pkg::CSM_PERIOD_SINGLE);
    wire m_perb = (mode == csm_pkg::CSM_PERIOD_BUF);
    wire m_gen = (mode == csm_pkg::CSM_PULSE_GEN);
    wire [CNT_W-1:0] cnt_inc = src_edge ? cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        save_d = save_q;
        latch = 1'b0;
        done_p = 1'b0;
        gen_d = gen_q;
        case (st_q)
            ST_OFF: begin
                if (arm_rise) begin
                    cnt_d = '0;
                    gen_d = 1'b0;
                    // buffered modes count from the arm itself
                    if (m_semib || m_perb) st_d = ST_RUN;
                    else if (m_gen) st_d = ST_RUN;
                    else st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // pulse width waits for a fresh leading edge even if armed mid-pulse
                if (gate_lead) begin
                    st_d = ST_RUN;
                    cnt_d = '0;
                end
            end
            ST_RUN: begin
                cnt_d = cnt_inc;
                if (m_semi1 && gate_trail) begin
                    save_d = cnt_q;
                    done_p = 1'b1;
                    st_d = ST_HOLD;
                end else if (m_per1 && gate_lead) begin
                    save_d = cnt_q;
                    done_p = 1'b1;
                    st_d = ST_HOLD;
                end else if ((m_semib && gate_any) || (m_perb && gate_lead)) begin
                    save_d = cnt_q;
                    latch = 1'b1;
                    cnt_d = src_edge ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
                end else if (m_gen) begin
                    // output stays high until the pulse_n-th source edge after arm
                    gen_d = 1'b1;
                    if (src_edge && cnt_inc >= pulse_n) begin
                        gen_d = 1'b0;
                        done_p = 1'b1;
                        st_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // further gate and source edges are ignored until re-armed
            end
            default: st_d = ST_OFF;
        endcase
        if (!arm) begin
            st_d = ST_OFF;
            gen_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // dma handoff, one-entry holding register
    // ------------------------------------------------------------------
    logic dv_q, ovr_q;
    logic [CNT_W-1:0] dd_q;
    wire dma_take = dv_q & dma_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_OFF;
            cnt_q <= '0;
            save_q <= '0;
            gen_q <= 1'b0;
            src_prev_q <= 1'b0;
            gate_prev_q <= 1'b0;
            arm_prev_q <= 1'b0;
            dv_q <= 1'b0;
            dd_q <= '0;
            ovr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            save_q <= save_d;
            gen_q <= gen_d;
            src_prev_q <= src;
            gate_prev_q <= gate;
            arm_prev_q <= arm;
            if (latch) begin
                dv_q <= 1'b1;
                dd_q <= save_d;
            end else if (dma_take) begin
                dv_q <= 1'b0;
            end
            // a new value while the old one is still waiting replaces it; the old one is lost
            ovr_q <= latch & dv_q & ~dma_ready;
        end
    end

    assign count = cnt_q;
    assign save = save_q;
    assign gen_out = gen_q;
    assign done = done_p;
    assign overrun = ovr_q;
    assign dma_valid = dv_q;
    assign dma_data = dd_q;

endmodule : csm_counter

// file: verilog/csm_top.sv
// csm_top: two measurement counters, apb register file, gate routing,
// interrupt status and two dma streams.
// assumes: apb master on pclk; all measured inputs asynchronous to pclk.
//
// Summary of operation
// - semi-period: every gate edge, either polarity, bounds an interval
// - count only the chosen polarity of timebase edge
// - single semi-period behaves as single pulse-width
// - pulse width: count while gate active, latch at inactive, then hold
// - buffered semi-period: latch on every gate edge, keep counting
// - each buffered value is offered in order to the dma controller unless the next value overwrites it first
// - counting begins at arm, so first buffered value is partial
// - low-frequency: one gate period in counts of a selectable timebase
// - averaged: buffered period measurements, software averages all but first
// - high-frequency: known-width gate pulse frames a pulse-width count
// - gate accepts pulses from function terminal or trigger bus
// - first counter generates a pulse lasting n source periods
// - first counter output routes to second counter gate
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module csm_top #(
    parameter int CNT_W = 32
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measured signals
    input wire logic [1:0] src_pin,
    input wire logic [1:0] slow_timebase,
    input wire logic fast_reference_timebase,
    input wire logic [1:0] gate_pin,
    input wire logic [1:0] general_function_terminal,
    input wire logic [1:0] interboard_trigger_bus,
    // dma streams
    output logic [1:0] dma_valid,
    output logic [CNT_W-1:0] dma_data0,
    output logic [CNT_W-1:0] dma_data1,
    input wire logic [1:0] dma_ready,
    // status
    output logic [1:0] gen_out,
    output logic irq
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("csm_top: CNT_W out of range");
    end

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int NSYN = 11;
    logic [NSYN-1:0] s1_q, s2_q;
    wire [NSYN-1:0] raw = {fast_reference_timebase, slow_timebase, src_pin, gate_pin,
                           general_function_terminal, interboard_trigger_bus};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire s_fast = s2_q[10];
    wire [1:0] s_slow = s2_q[9:8];
    wire [1:0] s_src = s2_q[7:6];
    wire [1:0] s_gate = s2_q[5:4];
    wire [1:0] s_gft = s2_q[3:2];
    wire [1:0] s_trig = s2_q[1:0];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl0_q, ctrl1_q, pulse_n_q;
    logic [csm_pkg::IRQ_W-1:0] stat_q, en_q;
    logic irq_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;

    wire setup = psel & ~penable;
    wire wr = setup & pwrite;
    wire rd = setup & ~pwrite;
    wire hit_ctrl0 = (paddr == csm_pkg::OFS_CTRL0);
    wire hit_ctrl1 = (paddr == csm_pkg::OFS_CTRL1);
    wire hit_save0 = (paddr == csm_pkg::OFS_SAVE0);
    wire hit_save1 = (paddr == csm_pkg::OFS_SAVE1);
    wire hit_pn = (paddr == csm_pkg::OFS_PULSE_N);
    wire hit_stat = (paddr == csm_pkg::OFS_IRQ_STAT);
    wire hit_en = (paddr == csm_pkg::OFS_IRQ_EN);
    wire hit_clr = (paddr == csm_pkg::OFS_IRQ_CLR);
    wire hit_cnt0 = (paddr == csm_pkg::OFS_CNT0);
    wire hit_cnt1 = (paddr == csm_pkg::OFS_CNT1);
    wire hit_any = hit_ctrl0 | hit_ctrl1 | hit_save0 | hit_save1 | hit_pn | hit_stat |
                   hit_en | hit_clr | hit_cnt0 | hit_cnt1;

    // ------------------------------------------------------------------
    // per-counter routing
    // ------------------------------------------------------------------
    wire [31:0] ctrl [2];
    assign ctrl[0] = ctrl0_q;
    assign ctrl[1] = ctrl1_q;
    wire [1:0] c_src, c_gate, c_gen, c_done, c_ovr;
    wire [CNT_W-1:0] c_cnt [2];
    wire [CNT_W-1:0] c_save [2];
    wire [CNT_W-1:0] c_dd [2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            wire [1:0] gsel = ctrl[gi][csm_pkg::CTL_GATE_SEL_LO +: csm_pkg::CTL_GATE_SEL_W];
            wire [1:0] ssel = ctrl[gi][csm_pkg::CTL_SRC_SEL +: 2];
            // slower timebase choice covers very slow gate signals
            assign c_src[gi] = (ssel == 2'h1) ? s_fast : (ssel == 2'h2) ? s_slow[gi] : s_src[gi];
            assign c_gate[gi] = (gsel == csm_pkg::GSEL_GFT) ? s_gft[gi] :
                                (gsel == csm_pkg::GSEL_TRIG) ? s_trig[gi] :
                                (gsel == csm_pkg::GSEL_PEER) ? c_gen[1-gi] : s_gate[gi];
            csm_counter #(.CNT_W(CNT_W)) u_cnt (
                .pclk(pclk),
                .presetn(presetn),
                .arm(ctrl[gi][csm_pkg::CTL_ARM]),
                .mode(ctrl[gi][csm_pkg::CTL_MODE_LO +: csm_pkg::CTL_MODE_W]),
                .src_fall(ctrl[gi][csm_pkg::CTL_SRC_FALL]),
                .gate_low(ctrl[gi][csm_pkg::CTL_GATE_LOW]),
                .pulse_n(pulse_n_q[CNT_W-1:0]),
                .src(c_src[gi]),
                .gate(c_gate[gi]),
                .count(c_cnt[gi]),
                .save(c_save[gi]),
                .gen_out(c_gen[gi]),
                .done(c_done[gi]),
                .overrun(c_ovr[gi]),
                .dma_valid(dma_valid[gi]),
                .dma_data(c_dd[gi]),
                .dma_ready(dma_ready[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt status: set wins over clear
    // ------------------------------------------------------------------
    wire [csm_pkg::IRQ_W-1:0] ev = {c_ovr[1], c_ovr[0], c_done[1], c_done[0]};
    wire [csm_pkg::IRQ_W-1:0] clr = (wr & hit_clr) ? pwdata[csm_pkg::IRQ_W-1:0] : '0;
    wire [csm_pkg::IRQ_W-1:0] stat_d = (stat_q & ~clr) | ev;

    function automatic logic [31:0] zx(input logic [CNT_W-1:0] v);
        zx = 32'h0000_0000;
        zx[CNT_W-1:0] = v;
    endfunction : zx

    wire [31:0] rd_mux = hit_ctrl0 ? ctrl0_q :
                         hit_ctrl1 ? ctrl1_q :
                         hit_save0 ? zx(c_save[0]) :
                         hit_save1 ? zx(c_save[1]) :
                         hit_pn ? pulse_n_q :
                         hit_stat ? {{(32-csm_pkg::IRQ_W){1'b0}}, stat_q} :
                         hit_en ? {{(32-csm_pkg::IRQ_W){1'b0}}, en_q} :
                         hit_cnt0 ? zx(c_cnt[0]) :
                         hit_cnt1 ? zx(c_cnt[1]) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q <= csm_pkg::CTRL_RST;
            ctrl1_q <= csm_pkg::CTRL_RST;
            pulse_n_q <= csm_pkg::PULSE_N_RST;
            en_q <= '0;
            stat_q <= '0;
            irq_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wr && hit_ctrl0) ctrl0_q <= pwdata;
            if (wr && hit_ctrl1) ctrl1_q <= pwdata;
            if (wr && hit_pn) pulse_n_q <= pwdata;
            if (wr && hit_en) en_q <= pwdata[csm_pkg::IRQ_W-1:0];
            stat_q <= stat_d;
            irq_q <= |(stat_d & en_q);
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            if (rd) prdata_q <= rd_mux;
        end
    end

    // dma outputs come from the counters' holding registers
    assign dma_data0 = c_dd[0];
    assign dma_data1 = c_dd[1];
    assign gen_out = c_gen;
    assign irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule : csm_top

// file: verif/csm_top_sva.sv
// csm_top_sva: port-level timing checks for csm_top.
// assumes: one pclk domain; bound into every csm_top below.
`timescale 1ns/100ps
module csm_top_sva #(
    parameter int CNT_W = 32
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // gate sources
    input wire logic [1:0] gate_pin,
    input wire logic [1:0] general_function_terminal,
    input wire logic [1:0] interboard_trigger_bus,
    // dma
    input wire logic [1:0] dma_valid,
    input wire logic [1:0] dma_ready
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // cycles since counter-0 gate pin, function terminal or trigger bus moved; a new latch needs a recent cause
    logic [2:0] gate_now;
    logic [2:0] gate_last_q;
    logic [3:0] gate_age_q;
    logic [3:0] gate_age_d;
    assign gate_now = {gate_pin[0], general_function_terminal[0], interboard_trigger_bus[0]};
    assign gate_age_d = (gate_now != gate_last_q) ? 4'h0 : gate_age_q + {3'h0, gate_age_q != 4'hf};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_last_q <= 3'h0;
            gate_age_q <= 4'hf;
        end else begin
            gate_last_q <= gate_now;
            gate_age_q <= gate_age_d;
        end
    end

    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_ready_after_setup; s_setup |=> s_access; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
    property p_ready_only_access; pready |-> $past(psel && !penable); endproperty
    a_ready_only_access: assert property (p_ready_only_access) else $error("stray pready");
    property p_err_with_ready; pslverr |-> pready && psel && penable; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr outside access");
    property p_unmapped_err; psel && !penable && paddr > csm_pkg::OFS_CNT1 |=> pslverr; endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
    property p_mapped_ok; psel && !penable && paddr <= csm_pkg::OFS_CNT1 && paddr[1:0] == 2'h0 |=> !pslverr; endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
    property p_valid_hold0; dma_valid[0] && !dma_ready[0] |=> dma_valid[0]; endproperty
    a_valid_hold0: assert property (p_valid_hold0) else $error("dma 0 value dropped");
    property p_valid_hold1; dma_valid[1] && !dma_ready[1] |=> dma_valid[1]; endproperty
    a_valid_hold1: assert property (p_valid_hold1) else $error("dma 1 value dropped");
    property p_latch_cause0; $rose(dma_valid[0]) |-> gate_age_q <= 4'h7; endproperty
    a_latch_cause0: assert property (p_latch_cause0) else $error("latch without gate edge");
endmodule : csm_top_sva

bind csm_top csm_top_sva #(.CNT_W(CNT_W)) u_csm_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .gate_pin(gate_pin),
    .general_function_terminal(general_function_terminal), .interboard_trigger_bus(interboard_trigger_bus),
    .dma_valid(dma_valid), .dma_ready(dma_ready));

// file: verif/csm_dma_model.sv
// csm_dma_model: dma controller stand-in draining one counter stream.
// assumes: valid/ready handshake on pclk; stall holds ready low.
`timescale 1ns/100ps
module csm_dma_model #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // counter stream
    input wire logic valid,
    input wire logic [CNT_W-1:0] data,
    output logic ready,
    // bench control
    input wire logic stall
);
    // values in arrival order, inspected by the bench
    logic [CNT_W-1:0] got_q[$];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready <= 1'b0;
        end else begin
            if (valid && ready) begin
                got_q.push_back(data);
            end
            ready <= !stall;
        end
    end
endmodule : csm_dma_model

// file: verif/tb_csm_top.sv
// tb_csm_top: directed scenarios for csm_top with two dma partner models.
// assumes: csm_pkg, csm_top, csm_dma_model and the checker compile first.
`timescale 1ns/100ps
module tb_csm_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic pready, pslverr, irq, fast_reference_timebase = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, dma_data0, dma_data1, rd_v;
    logic [1:0] src_pin = 2'h0, slow_timebase = 2'h0, gate_pin = 2'h0, general_function_terminal = 2'h0;
    logic [1:0] interboard_trigger_bus = 2'h0, dma_valid, dma_ready, gen_out, stall = 2'h0, gsel = 2'h0;
    int fail_count = 0, samples_checked = 0, gen_w = 0;

    always #10 pclk = ~pclk;
    always @(posedge pclk) fast_reference_timebase <= ~fast_reference_timebase;
    always @(posedge pclk) gen_w <= gen_w + int'(gen_out[0] === 1'b1);

    csm_top u_csm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_pin(src_pin),
        .slow_timebase(slow_timebase), .fast_reference_timebase(fast_reference_timebase), .gate_pin(gate_pin),
        .general_function_terminal(general_function_terminal), .interboard_trigger_bus(interboard_trigger_bus),
        .dma_valid(dma_valid), .dma_data0(dma_data0), .dma_data1(dma_data1), .dma_ready(dma_ready),
        .gen_out(gen_out), .irq(irq));
    csm_dma_model u_csm_dma_model_0 (.pclk(pclk), .presetn(presetn), .valid(dma_valid[0]), .data(dma_data0),
        .ready(dma_ready[0]), .stall(stall[0]));
    csm_dma_model u_csm_dma_model_1 (.pclk(pclk), .presetn(presetn), .valid(dma_valid[1]), .data(dma_data1),
        .ready(dma_ready[1]), .stall(stall[1]));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_v, exp);
    endtask : rd

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] ss, input logic f);
        ctl = {22'h0, gsel, ss, 1'b0, f, m, 1'b1};
    endfunction : ctl

    // set the routed gate source, then give n source pulses, each four cycles high and four low
    task automatic gp(input logic v, input int n);
        gate_pin <= (gsel == csm_pkg::GSEL_PIN) ? {2{v}} : 2'h0;
        general_function_terminal <= (gsel == csm_pkg::GSEL_GFT) ? {2{v}} : 2'h0;
        interboard_trigger_bus <= (gsel == csm_pkg::GSEL_TRIG) ? {2{v}} : 2'h0;
        repeat (2) @(posedge pclk);
        repeat (n) begin
            src_pin <= 2'h3;
            slow_timebase <= 2'h3;
            repeat (4) @(posedge pclk);
            src_pin <= 2'h0;
            slow_timebase <= 2'h0;
            repeat (4) @(posedge pclk);
        end
    endtask : gp

    task automatic t_regs();
        rd("ctrl0", csm_pkg::OFS_CTRL0, csm_pkg::CTRL_RST);
        rd("pulse_n", csm_pkg::OFS_PULSE_N, csm_pkg::PULSE_N_RST);
        apb(1'b1, csm_pkg::OFS_IRQ_STAT, 32'hf);
        rd("irq_stat", csm_pkg::OFS_IRQ_STAT, 32'h0);
        apb(1'b1, csm_pkg::OFS_IRQ_EN, 32'ha);
        rd("irq_en", csm_pkg::OFS_IRQ_EN, 32'ha);
        rd("irq_clr", csm_pkg::OFS_IRQ_CLR, 32'h0);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk("unmapped err", {31'h0, err}, 32'h1);
        rd("unmapped", 8'h40, 32'h0);
        apb(1'b1, csm_pkg::OFS_IRQ_EN, 32'h0);
        $display("regs test ended");
    endtask : t_regs

    task automatic t_semi_buf();
        gsel = csm_pkg::GSEL_PIN;
        apb(1'b1, csm_pkg::OFS_CTRL0, ctl(csm_pkg::CSM_SEMI_BUF, 2'h0, 1'b0));
        gp(1'b0, 2);
        gp(1'b1, 3);
        gp(1'b0, 5);
        gp(1'b1, 1);
        apb(1'b1, csm_pkg::OFS_CTRL0, 32'h0);
        chk("count", u_csm_dma_model_0.got_q.size(), 32'h3);
        chk("partial", u_csm_dma_model_0.got_q[0], 32'h2);
        chk("rise half", u_csm_dma_model_0.got_q[1], 32'h3);
        chk("fall half", u_csm_dma_model_0.got_q[2], 32'h5);
        u_csm_dma_model_0.got_q.delete();
        $display("buffered semi-period test ended");
    endtask : t_semi_buf

    task automatic t_single(input logic [1:0] gs, input logic [1:0] ss);
        gsel = gs;
        apb(1'b1, csm_pkg::OFS_IRQ_CLR, 32'hf);
        apb(1'b1, csm_pkg::OFS_CTRL0, ctl(csm_pkg::CSM_SEMI_SINGLE, ss, 1'b1));
        gp(1'b0, 2);
        gp(1'b1, 4);
        gp(1'b0, 3);
        gp(1'b1, 2);
        gp(1'b0, 1);
        rd("save0", csm_pkg::OFS_SAVE0, 32'h4);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, csm_pkg::OFS_IRQ_EN, 32'h1);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, csm_pkg::OFS_IRQ_CLR, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, csm_pkg::OFS_IRQ_EN, 32'h0);
        apb(1'b1, csm_pkg::OFS_CTRL0, 32'h0);
        $display("single semi-period test ended");
    endtask : t_single

    task automatic t_overrun();
        gsel = csm_pkg::GSEL_PIN;
        stall <= 2'h1;
        apb(1'b1, csm_pkg::OFS_CTRL0, ctl(csm_pkg::CSM_PERIOD_BUF, 2'h0, 1'b0));
        gp(1'b0, 1);
        gp(1'b1, 2);
        gp(1'b0, 1);
        gp(1'b1, 1);
        rd("overrun", csm_pkg::OFS_IRQ_STAT, 32'h4);
        stall <= 2'h0;
        apb(1'b1, csm_pkg::OFS_CTRL0, 32'h0);
        chk("taken", u_csm_dma_model_0.got_q.size(), 32'h1);
        chk("period", u_csm_dma_model_0.got_q[0], 32'h3);
        $display("overrun test ended");
    endtask : t_overrun

    task automatic t_large();
        int w0;
        apb(1'b1, csm_pkg::OFS_IRQ_CLR, 32'hf);
        apb(1'b1, csm_pkg::OFS_PULSE_N, 32'h3);
        gsel = csm_pkg::GSEL_PEER;
        apb(1'b1, csm_pkg::OFS_CTRL1, ctl(csm_pkg::CSM_SEMI_SINGLE, 2'h1, 1'b0));
        gsel = csm_pkg::GSEL_PIN;
        w0 = gen_w;
        apb(1'b1, csm_pkg::OFS_CTRL0, ctl(csm_pkg::CSM_PULSE_GEN, 2'h0, 1'b0));
        gp(1'b0, 4);
        w0 = gen_w - w0;
        chk("gen width", {31'h0, w0 inside {[18:24]}}, 32'h1);
        apb(1'b0, csm_pkg::OFS_SAVE1, 32'h0);
        // the timebase rises every second cycle, so j is half the pulse width
        chk("j", {31'h0, (2 * int'(rd_v) - w0) inside {[-2:2]}}, 32'h1);
        rd("done", csm_pkg::OFS_IRQ_STAT, 32'h3);
        apb(1'b1, csm_pkg::OFS_CTRL0, 32'h0);
        apb(1'b1, csm_pkg::OFS_CTRL1, 32'h0);
        $display("large range test ended");
    endtask : t_large

    // active-low gate: falls are the active edges, rises are ignored
    task automatic t_period();
        gsel = csm_pkg::GSEL_PIN;
        apb(1'b1, csm_pkg::OFS_CTRL0, ctl(csm_pkg::CSM_PERIOD_SINGLE, 2'h0, 1'b0) | (32'h1 << csm_pkg::CTL_GATE_LOW));
        gp(1'b1, 1);
        gp(1'b0, 2);
        gp(1'b1, 1);
        gp(1'b0, 1);
        gp(1'b1, 1);
        rd("period single", csm_pkg::OFS_SAVE0, 32'h3);
        apb(1'b1, csm_pkg::OFS_CTRL0, 32'h0);
        $display("single period test ended");
    endtask : t_period

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_semi_buf();
        t_single(csm_pkg::GSEL_GFT, 2'h0);
        t_single(csm_pkg::GSEL_TRIG, 2'h2);
        t_overrun();
        t_large();
        t_period();
        finish_test();
    end

    // the scenarios need about 600 cycles; over thirty times that means a hang
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
endmodule : tb_csm_top
